// [rtl/switching_freq_sync_config.sv]
// switching frequency, sync lock and interleave phase configuration
// assumes sync_i and en_pin_i are synchronous to mclk_i
//
// What this block does
// - switching frequency 300 kHz to 1 MHz, from strap or bus command.
// - clock strap sampled once after reset, later changes ignored.
// - open clock strap is a fault and gives 575 kHz.
// - running frequency changes allowed only on the same side of 475 kHz.
// - clock strap bins decode to 575, then 300..1000 by 50, then 575.
// - voltage strap bins decode to track, table voltages, then 0 V.
// - once enabled, pwm timing locks to sync rising edges.
// - sync lost after lock: free-run at the stored frequency.
// - sync toggling during strap read: no strap frequency stored.
// - no sync during strap read: decoded strap frequency stored.
// - sync present at enable: measured frequency overwrites the setting.
// - sync first seen after enable: lock without touching the setting.
// - default phase from low three address bits via fixed table.
// - phase writes accepted only while output is disabled.
// - phase delay runs from sync rising edge to pwm pulse centre.
// - bus address from both address straps, fixed after startup.
// - high address strap also selects default current sense gain.
// - output enabled by enable pin or bus enable bit.
//
// Decided for this implementation: strobed register access and the placing of the registers.
module switching_freq_sync_config
  import sync_cfg_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  input  wire logic                      en_pin_i,
  input  wire logic                      sync_i,
  input  wire sync_cfg_pkg::strap_bins_t strap_bins_i,
  input  wire logic [7:0]                bus_addr_i,
  input  wire logic [15:0]               bus_wdata_i,
  input  wire logic                      bus_wr_i,
  input  wire logic                      bus_rd_i,
  output logic      [15:0]               bus_rdata_o,
  output logic                           output_en_o,
  output logic                           sync_locked_o,
  output logic                           pwm_center_o,
  output logic                           pwm_boundary_o,
  output sync_cfg_pkg::strap_cfg_t       cfg_o
);

  strap_cfg_t  cfg_d;
  logic [15:0] strap_timer;
  logic        strap_done;
  logic        strap_seen;
  logic        strap_unres;
  logic        sync_q;
  logic        sync_rise;
  logic [15:0] gap_cnt;
  logic [15:0] sync_period;
  logic [1:0]  edges;
  logic        sync_present;
  logic        bus_on;
  logic        en_req;
  logic        en_rise;
  logic [15:0] freq_khz;
  logic [15:0] phase_deg;
  logic        wr_rejected;
  logic        freq_ok;
  logic        phase_ok;
  logic        wr_freq;
  logic        wr_phase;
  logic        need_meas;
  logic        need_freq;
  logic        need_phase;
  job_t        job;
  job_t        next_job;
  logic        div_start;
  logic [15:0] div_num;
  logic [15:0] div_den;
  logic [15:0] div_quot;
  logic        div_done;
  logic [15:0] period_pend;
  logic [15:0] phase_cyc;
  logic [15:0] active_period;
  logic [15:0] pwm_cnt;
  logic        wrap;

  // ----------------------------------------------------------------
  // decode and divide
  // ----------------------------------------------------------------
  strap_decode u_decode (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .bins_i (strap_bins_i),
    .cfg_o  (cfg_d)
  );

  serial_divider u_div (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .start_i (div_start),
    .num_i   (div_num),
    .den_i   (div_den),
    .quot_o  (div_quot),
    .done_o  (div_done)
  );

  // ----------------------------------------------------------------
  // strap sampling window
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      strap_timer <= '0;
      strap_done  <= 1'b0;
      strap_seen  <= 1'b0;
      strap_unres <= 1'b0;
      cfg_o       <= '0;
    end else if (!strap_done) begin
      strap_timer <= strap_timer + 16'h0001;
      if (sync_rise) begin
        strap_seen <= 1'b1;
      end
      if (strap_timer == 16'(STRAP_WINDOW_CYC - 1)) begin
        strap_done  <= 1'b1;
        strap_unres <= strap_seen | sync_rise;
        cfg_o       <= cfg_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // sync edge and period measurement
  // ----------------------------------------------------------------
  assign sync_rise = sync_i & ~sync_q;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync_q       <= 1'b0;
      gap_cnt      <= '0;
      sync_period  <= RESET_PERIOD_CYC;
      edges        <= '0;
      sync_present <= 1'b0;
    end else begin
      sync_q <= sync_i;
      if (sync_rise) begin
        gap_cnt <= '0;
        if (edges != 2'h0) begin
          sync_period  <= gap_cnt + 16'h0001;
          sync_present <= 1'b1;
        end
        edges <= 2'h1;
      end else if (gap_cnt == 16'(SYNC_LOSS_CYC)) begin
        edges        <= '0;
        sync_present <= 1'b0;
      end else begin
        gap_cnt <= gap_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // enable and lock
  // ----------------------------------------------------------------
  assign en_req  = (en_pin_i | bus_on) & strap_done;
  assign en_rise = en_req & ~output_en_o;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      output_en_o   <= 1'b0;
      sync_locked_o <= 1'b0;
    end else begin
      output_en_o   <= en_req;
      sync_locked_o <= en_req & sync_present;
    end
  end

  // ----------------------------------------------------------------
  // bus writes
  // ----------------------------------------------------------------
  assign wr_freq  = bus_wr_i && bus_addr_i == REG_FREQ;
  assign wr_phase = bus_wr_i && bus_addr_i == REG_PHASE;
  assign freq_ok  = bus_wdata_i >= FREQ_MIN_KHZ && bus_wdata_i <= FREQ_MAX_KHZ
                    && (!output_en_o
                    || ((bus_wdata_i > FREQ_SPLIT_KHZ) == (freq_khz > FREQ_SPLIT_KHZ)));
  assign phase_ok = !output_en_o && bus_wdata_i < PHASE_FULL_DEG;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_on <= CTRL_RESET[0];
    end else if (bus_wr_i && bus_addr_i == REG_CTRL) begin
      bus_on <= bus_wdata_i[0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wr_rejected <= 1'b0;
    end else if ((wr_freq && !freq_ok) || (wr_phase && !phase_ok)) begin
      wr_rejected <= 1'b1;
    end else if (bus_rd_i && bus_addr_i == REG_STATUS) begin
      wr_rejected <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      freq_khz <= FREQ_FAULT_KHZ;
    end else if (!strap_done && strap_timer == 16'(STRAP_WINDOW_CYC - 1)) begin
      if (!(strap_seen | sync_rise)) begin
        freq_khz <= cfg_d.freq_khz;
      end
    end else if (div_done && job == JOB_MEAS) begin
      freq_khz <= div_quot;
    end else if (wr_freq && freq_ok) begin
      freq_khz <= bus_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase_deg <= '0;
    end else if (!strap_done && strap_timer == 16'(STRAP_WINDOW_CYC - 1)) begin
      phase_deg <= cfg_d.phase_deg;
    end else if (wr_phase && phase_ok) begin
      phase_deg <= bus_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // conversion jobs
  // ----------------------------------------------------------------
  always_comb begin
    next_job = JOB_IDLE;
    div_num  = 16'(CLK_KHZ);
    div_den  = freq_khz;
    if (need_meas) begin
      next_job = JOB_MEAS;
      div_den  = sync_period;
    end else if (need_freq) begin
      next_job = JOB_FREQ;
    end else if (need_phase) begin
      next_job = JOB_PHASE;
      div_num  = 16'(period_pend * phase_deg);
      div_den  = PHASE_FULL_DEG;
    end
    div_start = (job == JOB_IDLE) && (next_job != JOB_IDLE);
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      job <= JOB_IDLE;
    end else begin
      unique case (job)
        JOB_IDLE:  job <= next_job;
        JOB_MEAS:  if (div_done) job <= JOB_IDLE;
        JOB_FREQ:  if (div_done) job <= JOB_IDLE;
        JOB_PHASE: if (div_done) job <= JOB_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      need_meas <= 1'b0;
    end else if (en_rise && sync_present) begin
      need_meas <= 1'b1;
    end else if (div_start && next_job == JOB_MEAS) begin
      need_meas <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      need_freq <= 1'b1;
    end else if ((wr_freq && freq_ok) || (div_done && job == JOB_MEAS)
                 || (!strap_done && strap_timer == 16'(STRAP_WINDOW_CYC - 1))) begin
      need_freq <= 1'b1;
    end else if (div_start && next_job == JOB_FREQ) begin
      need_freq <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      need_phase <= 1'b1;
    end else if ((wr_phase && phase_ok) || (div_done && job == JOB_FREQ)) begin
      need_phase <= 1'b1;
    end else if (div_start && next_job == JOB_PHASE) begin
      need_phase <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      period_pend <= RESET_PERIOD_CYC;
      phase_cyc   <= '0;
    end else if (div_done && job == JOB_FREQ) begin
      period_pend <= div_quot;
    end else if (div_done && job == JOB_PHASE) begin
      phase_cyc <= div_quot;
    end
  end

  // ----------------------------------------------------------------
  // pwm period timer
  // ----------------------------------------------------------------
  assign wrap = pwm_cnt >= active_period - 16'h0001;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwm_cnt       <= '0;
      active_period <= RESET_PERIOD_CYC;
    end else if (!output_en_o) begin
      pwm_cnt       <= '0;
      active_period <= period_pend;
    end else if (sync_locked_o && sync_rise) begin
      pwm_cnt <= (phase_cyc == 16'h0000) ? 16'h0000 : active_period - phase_cyc;
    end else if (wrap) begin
      pwm_cnt       <= '0;
      active_period <= period_pend;
    end else begin
      pwm_cnt <= pwm_cnt + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwm_center_o   <= 1'b0;
      pwm_boundary_o <= 1'b0;
    end else begin
      pwm_center_o   <= output_en_o && pwm_cnt == 16'h0000;
      pwm_boundary_o <= output_en_o && wrap;
    end
  end

  // ----------------------------------------------------------------
  // bus reads
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_rdata_o <= '0;
    end else begin
      bus_rdata_o <= '0;
      if (bus_rd_i) begin
        unique case (bus_addr_i)
          REG_CTRL:   bus_rdata_o <= {15'h0000, bus_on};
          REG_FREQ:   bus_rdata_o <= freq_khz;
          REG_PHASE:  bus_rdata_o <= phase_deg;
          REG_STATUS: bus_rdata_o <= {8'h00, cfg_o.track, wr_rejected, strap_done,
                                      strap_unres, cfg_o.sync_fault, sync_locked_o,
                                      sync_present, output_en_o};
          REG_ADDR:   bus_rdata_o <= {9'h000, cfg_o.addr};
          REG_VOUT:   bus_rdata_o <= cfg_o.vout_mv;
          REG_GAIN:   bus_rdata_o <= {8'h00, cfg_o.gain_mohm};
          REG_PERIOD: bus_rdata_o <= active_period;
          default:    bus_rdata_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  property p_strap_once;
    strap_done |=> $stable(cfg_o) && strap_done;
  endproperty
  a_strap_once: assert property (p_strap_once) else $error("strap config moved");

  property p_open_fault;
    cfg_d.sync_fault |-> cfg_d.freq_khz == FREQ_FAULT_KHZ;
  endproperty
  a_open_fault: assert property (p_open_fault) else $error("open strap not 575");

  property p_strap_store;
    $rose(strap_done) && !strap_unres |-> freq_khz == $past(cfg_d.freq_khz);
  endproperty
  a_strap_store: assert property (p_strap_store) else $error("strap freq lost");

  property p_strap_unres;
    $rose(strap_done) && strap_unres |-> $stable(freq_khz);
  endproperty
  a_strap_unres: assert property (p_strap_unres) else $error("unresolved strap");

  property p_band;
    wr_freq && output_en_o && ((bus_wdata_i > FREQ_SPLIT_KHZ) != (freq_khz > FREQ_SPLIT_KHZ))
      && !(div_done && job == JOB_MEAS) |=> $stable(freq_khz) && wr_rejected;
  endproperty
  a_band: assert property (p_band) else $error("band crossed");

  property p_phase_lock;
    wr_phase && output_en_o |=> $stable(phase_deg);
  endproperty
  a_phase_lock: assert property (p_phase_lock) else $error("phase moved");

  property p_boundary;
    $changed(active_period) |-> $past(wrap) || !$past(output_en_o);
  endproperty
  a_boundary: assert property (p_boundary) else $error("period cut");

  property p_sync_align;
    output_en_o && sync_locked_o && sync_rise && phase_cyc == 16'h0000 |=> pwm_cnt == 16'h0000;
  endproperty
  a_sync_align: assert property (p_sync_align) else $error("not aligned");

  property p_meas;
    en_rise && sync_present |=> need_meas ##[1:40] job == JOB_MEAS;
  endproperty
  a_meas: assert property (p_meas) else $error("no measure");

  property p_late_sync;
    output_en_o && $past(output_en_o) && $rose(sync_locked_o) |-> !need_meas;
  endproperty
  a_late_sync: assert property (p_late_sync) else $error("late sync measured");

  c_enable_sync: cover property (en_rise && sync_present ##[1:60] job == JOB_PHASE);
  c_reject:      cover property (wr_freq && output_en_o && !freq_ok);
  c_sync_loss:   cover property (sync_locked_o ##1 !sync_locked_o && output_en_o);

endmodule : switching_freq_sync_config

// [rtl/sync_cfg_pkg.sv]
// package: constants, carriers and state codes of the frequency/sync config
// assumes a single 40 MHz clock domain
package sync_cfg_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 25;
  localparam int CLK_KHZ          = 40000;
  localparam int STRAP_WINDOW_NS  = 10000;
  localparam int STRAP_WINDOW_CYC = (STRAP_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_LOSS_NS     = 5000;
  localparam int SYNC_LOSS_CYC    = (SYNC_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  // ----------------------------------------------------------------
  // frequency, phase and strap codes
  // ----------------------------------------------------------------
  localparam logic [15:0] FREQ_MIN_KHZ   = 16'h012c;
  localparam logic [15:0] FREQ_MAX_KHZ   = 16'h03e8;
  localparam logic [15:0] FREQ_SPLIT_KHZ = 16'h01db;
  localparam logic [15:0] FREQ_FAULT_KHZ = 16'h023f;
  localparam logic [15:0] FREQ_STEP_KHZ  = 16'h0032;
  localparam logic [15:0] PHASE_FULL_DEG = 16'h0168;
  localparam logic [15:0] RESET_PERIOD_CYC = 16'(CLK_KHZ / int'(FREQ_FAULT_KHZ));
  localparam logic [4:0]  BIN_OPEN       = 5'h1f;
  localparam logic [4:0]  SYNC_BIN_TOP   = 5'h0f;
  localparam logic [4:0]  VSET_BIN_TOP   = 5'h10;
  localparam logic [4:0]  ADDR_LO_BIN_MAX = 5'h17;
  localparam logic [4:0]  ADDR_HI_BIN_MAX = 5'h18;
  localparam logic [4:0]  HI_BINS_PER_ROW = 5'h05;
  localparam logic [7:0]  ADDR_BASE      = 8'h0a;
  localparam logic [7:0]  ADDR_COL_STEP  = 8'h18;
  localparam logic [7:0]  ADDR_MAX       = 8'h7f;
  localparam logic [7:0]  GAIN_STEP_MOHM = 8'h04;
  localparam logic [15:0] VOUT_MV [16] = '{16'h0258, 16'h02bc, 16'h02ee, 16'h0320,
                                           16'h0352, 16'h0384, 16'h03b6, 16'h03e8,
                                           16'h041a, 16'h044c, 16'h04b0, 16'h05dc,
                                           16'h0708, 16'h09c4, 16'h0ce4, 16'h1388};
  localparam logic [15:0] PHASE_DEG [8] = '{16'h0000, 16'h003c, 16'h0078, 16'h00b4,
                                            16'h00f0, 16'h012c, 16'h005a, 16'h010e};

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_FREQ   = 8'h04;
  localparam logic [7:0] REG_PHASE  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_ADDR   = 8'h10;
  localparam logic [7:0] REG_VOUT   = 8'h14;
  localparam logic [7:0] REG_GAIN   = 8'h18;
  localparam logic [7:0] REG_PERIOD = 8'h1c;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] sync_bin;
    logic [4:0] vset_bin;
    logic [4:0] addr_lo_bin;
    logic [4:0] addr_hi_bin;
  } strap_bins_t;

  typedef struct packed {
    logic [15:0] freq_khz;
    logic        sync_fault;
    logic [15:0] vout_mv;
    logic        track;
    logic [6:0]  addr;
    logic [7:0]  gain_mohm;
    logic [15:0] phase_deg;
  } strap_cfg_t;

  typedef enum logic [1:0] {
    JOB_IDLE  = 2'b00,
    JOB_MEAS  = 2'b01,
    JOB_FREQ  = 2'b11,
    JOB_PHASE = 2'b10
  } job_t;

endpackage : sync_cfg_pkg

// [rtl/strap_decode.sv]
// strap bin decoder: frequency, output voltage, bus address, gain, phase
// assumes bins are steady; result registered every clock
module strap_decode
  import sync_cfg_pkg::*;
(
  input  wire logic                       mclk_i,
  input  wire logic                       rst_i,
  input  wire sync_cfg_pkg::strap_bins_t  bins_i,
  output sync_cfg_pkg::strap_cfg_t        cfg_o
);

  strap_cfg_t next_cfg;
  logic [4:0] lo;
  logic [4:0] hi;
  logic [7:0] sum;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    next_cfg = '0;
    lo  = (bins_i.addr_lo_bin > ADDR_LO_BIN_MAX) ? ADDR_LO_BIN_MAX : bins_i.addr_lo_bin;
    hi  = (bins_i.addr_hi_bin > ADDR_HI_BIN_MAX) ? ADDR_HI_BIN_MAX : bins_i.addr_hi_bin;
    sum = ADDR_BASE + 8'(lo) + 8'(hi % HI_BINS_PER_ROW) * ADDR_COL_STEP;
    if (sum > ADDR_MAX) begin
      sum = ADDR_MAX;
    end
    next_cfg.addr      = sum[6:0];
    next_cfg.gain_mohm = GAIN_STEP_MOHM * (8'(hi / HI_BINS_PER_ROW) + 8'h01);
    next_cfg.phase_deg = PHASE_DEG[sum[2:0]];
    next_cfg.sync_fault = (bins_i.sync_bin == BIN_OPEN);
    if (bins_i.sync_bin == 5'h00 || bins_i.sync_bin > SYNC_BIN_TOP) begin
      next_cfg.freq_khz = FREQ_FAULT_KHZ;
    end else begin
      next_cfg.freq_khz = FREQ_MIN_KHZ + FREQ_STEP_KHZ * 16'(bins_i.sync_bin - 5'h01);
    end
    next_cfg.track = (bins_i.vset_bin == 5'h00);
    if (bins_i.vset_bin != 5'h00 && bins_i.vset_bin <= VSET_BIN_TOP) begin
      next_cfg.vout_mv = VOUT_MV[4'(bins_i.vset_bin - 5'h01)];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o <= next_cfg;
    end
  end

endmodule : strap_decode

// [rtl/serial_divider.sv]
// serial restoring divider, one quotient bit per clock
// assumes operands stay valid only in the start cycle
module serial_divider
  import sync_cfg_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        start_i,
  input  wire logic [15:0] num_i,
  input  wire logic [15:0] den_i,
  output logic      [15:0] quot_o,
  output logic             done_o
);

  logic [15:0] rem;
  logic [15:0] den;
  logic [4:0]  step;
  logic        busy;
  logic [16:0] sh;

  assign sh = {rem, quot_o[15]};

  // ----------------------------------------------------------------
  // iterate
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rem    <= '0;
      den    <= '0;
      quot_o <= '0;
      step   <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        rem    <= '0;
        den    <= den_i;
        quot_o <= num_i;
        step   <= '0;
        busy   <= 1'b1;
      end else if (busy) begin
        if (sh >= {1'b0, den}) begin
          rem    <= 16'(sh - {1'b0, den});
          quot_o <= {quot_o[14:0], 1'b1};
        end else begin
          rem    <= sh[15:0];
          quot_o <= {quot_o[14:0], 1'b0};
        end
        step <= step + 5'h01;
        if (step == DIV_STEPS - 5'h01) begin
          busy   <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule : serial_divider

// [tb/sync_source.sv]
// sync clock source model at the far side of the sync pin
// assumes mclk_i is the bench clock
module sync_source (
  input  wire logic mclk_i,
  input  wire logic on_i,
  output logic      sync_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial sync_o = 1'b0;
  // steady 80-cycle period, low while stopped
  always @(posedge mclk_i) begin
    cnt <= on_i ? (cnt + 1) % 80 : 0;
    sync_o <= on_i && cnt >= 40;
  end
endmodule : sync_source

// [tb/switching_freq_sync_config_test.sv]
// self-checking bench of the frequency/sync config block
// assumes sync_source model and 40 MHz clock
module switching_freq_sync_config_test;
  import sync_cfg_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 0, rst_i = 1, en_pin_i = 0, bus_wr_i = 0, bus_rd_i = 0, on = 0, sync_i;
  logic output_en_o, sync_locked_o, pwm_center_o, pwm_boundary_o, sync_p = 0;
  logic [7:0] bus_addr_i = 8'h00;
  logic [15:0] bus_wdata_i = 16'h0000, bus_rdata_o, got;
  strap_bins_t strap_bins_i = '0;
  strap_cfg_t cfg_o;
  int error_cnt = 0, checks = 0, cyc = 0, rise_cyc = 0, gap = 0, bcyc = 0, bgap = 0;
  int f, nf, lo, hi, a, v;
  always #12.5 mclk_i = ~mclk_i;
  switching_freq_sync_config switching_freq_sync_config_inst (.mclk_i, .rst_i, .en_pin_i,
    .sync_i, .strap_bins_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_rdata_o,
    .output_en_o, .sync_locked_o, .pwm_center_o, .pwm_boundary_o, .cfg_o);
  sync_source sync_source_inst (.mclk_i, .on_i(on), .sync_o(sync_i));
  // sync rise to first pwm centre, and spacing of period boundaries
  always @(posedge mclk_i) begin
    cyc++;
    sync_p <= sync_i;
    if (sync_i === 1'b1 && sync_p === 1'b0 && sync_locked_o === 1'b1) rise_cyc <= cyc;
    else if (pwm_center_o === 1'b1 && rise_cyc > 0 && cyc - rise_cyc >= 2) begin
      gap <= cyc - rise_cyc;
      rise_cyc <= 0;
    end
    if (pwm_boundary_o === 1'b1) begin
      bgap <= cyc - bcyc;
      bcyc <= cyc;
    end
    if (cyc == 8000) begin
      error_cnt++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] ad, int d);
    @(posedge mclk_i);
    bus_addr_i <= ad;
    bus_wdata_i <= 16'(d);
    bus_wr_i <= 1'b1;
    @(posedge mclk_i);
    bus_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] ad);
    @(posedge mclk_i);
    bus_addr_i <= ad;
    bus_rd_i <= 1'b1;
    @(posedge mclk_i);
    bus_rd_i <= 1'b0;
    #1 got = bus_rdata_o;
  endtask : rd
  task automatic boot();
    rst_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    repeat (410) @(posedge mclk_i);
  endtask : boot
  task automatic final_report();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(24549));
    v = $urandom_range(16, 1);
    strap_bins_i <= {5'h1f, 5'(v), 5'h1f, 5'h1f};
    boot();
    rd(REG_FREQ);
    chk("open freq", FREQ_FAULT_KHZ, got);
    rd(REG_STATUS);
    chk("open flag", 16'h0001, 16'(got[3]));
    chk("vout", VOUT_MV[v - 1], cfg_o.vout_mv);
    nf = $urandom_range(15, 1);
    lo = $urandom_range(23, 0);
    hi = $urandom_range(24, 0);
    strap_bins_i <= {5'(nf), 5'h00, 5'(lo), 5'(hi)};
    boot();
    strap_bins_i <= '1;
    f = 250 + 50 * nf;
    a = (10 + lo + 24 * (hi % 5) > 127) ? 127 : 10 + lo + 24 * (hi % 5);
    rd(REG_FREQ);
    chk("strap freq", 16'(f), got);
    chk("addr", 16'(a), 16'(cfg_o.addr));
    chk("phase", PHASE_DEG[a % 8], cfg_o.phase_deg);
    chk("gain", 16'(4 * (hi / 5 + 1)), 16'(cfg_o.gain_mohm));
    chk("track", 16'h0001, 16'(cfg_o.track));
    wr(REG_PHASE, 90);
    rd(REG_PHASE);
    chk("phase wr", 16'h005a, got);
    wr(REG_CTRL, 1);
    repeat (2) @(posedge mclk_i);
    chk("bus enable", 16'h0001, 16'(output_en_o));
    wr(REG_PHASE, 180);
    rd(REG_PHASE);
    chk("phase locked", 16'h005a, got);
    on <= 1'b1;
    repeat (300) @(posedge mclk_i);
    chk("lock", 16'h0001, 16'(sync_locked_o));
    chk("centre", 16'((40000 / f) * 90 / 360 + 2), 16'(gap));
    rd(REG_FREQ);
    chk("late sync freq", 16'(f), got);
    on <= 1'b0;
    repeat (400) @(posedge mclk_i);
    chk("lost", 16'h0000, 16'(sync_locked_o));
    chk("still on", 16'h0001, 16'(output_en_o));
    chk("free period", 16'(40000 / f), 16'(bgap));
    repeat (6) begin
      nf = $urandom_range(1050, 250);
      wr(REG_FREQ, nf);
      if (nf >= 300 && nf <= 1000 && (f <= 475) == (nf <= 475)) f = nf;
      rd(REG_FREQ);
      chk("run freq", 16'(f), got);
    end
    nf = (f <= 475) ? 900 : 400;
    wr(REG_FREQ, nf);
    rd(REG_FREQ);
    chk("cross on", 16'(f), got);
    rd(REG_STATUS);
    chk("reject", 16'h0001, 16'(got[6]));
    wr(REG_CTRL, 0);
    wr(REG_FREQ, nf);
    rd(REG_FREQ);
    chk("cross off", 16'(nf), got);
    rd(8'h40);
    chk("unmapped", 16'h0000, got);
    // clock applied before reset and enable
    on <= 1'b1;
    boot();
    rd(REG_FREQ);
    chk("busy strap", FREQ_FAULT_KHZ, got);
    wr(REG_PHASE, 0);
    rd(REG_PHASE);
    chk("phase zero", 16'h0000, got);
    en_pin_i <= 1'b1;
    repeat (200) @(posedge mclk_i);
    chk("pin enable", 16'h0001, 16'(output_en_o));
    rd(REG_FREQ);
    chk("measured", 16'h01f4, got);
    final_report();
  end
endmodule : switching_freq_sync_config_test
